// File: tgcc_pkg.sv
// ==================================================================
// Shared constants of the timer general register mode control block
// ==================================================================
package tgcc_pkg;

  // ================================================================
  // Sizes
  // ================================================================
  localparam int NUM_GR = 22;           // ch2: 8, ch3..5: 4 each, ch11: 2
  localparam int NUM_CNT = 5;           // Counters of ch2, ch3, ch4, ch5, ch11
  localparam int NUM_MODE = 11;         // Pin function control registers
  localparam int NUM_FLAG = 27;         // 22 capture/match flags + 5 overflow
  localparam int GR_W = 16;             // General register and counter width

  // ================================================================
  // Index ranges of the general registers
  // ================================================================
  localparam int GR_CH3_FIRST = 8;      // First channel 3 register
  localparam int GR_CH4_FIRST = 12;     // First channel 4 register
  localparam int GR_CH5_FIRST = 16;     // First channel 5 register
  localparam int GR_CH11_FIRST = 20;    // First channel 11 register
  localparam int OVF_BIT = 8;           // Overflow flag position in a flag register

  // ================================================================
  // Register map, byte addresses (one 32-bit word each)
  // ================================================================
  localparam logic [11:0] MODE_BASE = 12'h000;   // 11 pin function control regs
  localparam logic [11:0] GR_BASE = 12'h040;     // 22 general registers
  localparam logic [11:0] CNT_BASE = 12'h0c0;    // 5 free-running counters
  localparam logic [11:0] FLAG_BASE = 12'h0e0;   // 5 flag registers
  localparam logic [11:0] IEN_BASE = 12'h100;    // 5 interrupt enable registers
  localparam logic [11:0] RUN_ADDR = 12'h120;    // Counter run bits [4:0]

  // ================================================================
  // Field layouts and reset values
  // ================================================================
  localparam logic [7:0] MODE_RST = 8'h00;       // Control registers after reset
  localparam logic [7:0] MASK_RSVD = 8'h77;      // ch2/ch11: bits 7 and 3 read 0
  localparam logic [7:0] MASK_FULL = 8'hff;      // ch3..5: bits 7 and 3 are clear enables
  localparam logic [15:0] FLAG_RST = 16'h0000;   // Flag registers after reset
  localparam logic [15:0] CNT_MAX = 16'hffff;    // Counter wrap point
  localparam logic [2:0] MD_CMP_OFF = 3'h0;      // Compare disabled
  localparam logic [2:0] MD_CMP_LOW = 3'h1;      // Drive 0 on match
  localparam logic [2:0] MD_CMP_HIGH = 3'h2;     // Drive 1 on match
  localparam logic [2:0] MD_CMP_TOG = 3'h3;      // Toggle on match
  localparam logic [2:0] MD_CAP_OFF = 3'h4;      // Capture from pin disabled
  localparam logic [2:0] MD_CAP_RISE = 3'h5;     // Capture on rising edge
  localparam logic [2:0] MD_CAP_FALL = 3'h6;     // Capture on falling edge
  localparam logic [2:0] MD_CAP_BOTH = 3'h7;     // Capture on both edges

endpackage

// File: tgcc_core.sv
`timescale 1ns/1ps

module tgcc_core (
  input wire logic core_clk_i,                 // Peripheral clock, 40 MHz
  input wire logic resetn_i,                   // Power-on reset, active low
  input wire logic standby_i,                  // Hardware or software standby
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Timer side
  input wire logic [21:0] timer_pin_i,         // Capture inputs, one per register
  output logic [21:0] timer_pin_o,             // Compare outputs
  output logic [21:0] timer_pin_oe_o,          // High while compare drives the pin
  input wire logic ch9_match_i,                // Channel 9 event-count match pulse
  output logic irq_o                           // Interrupt request to the processor
);

  // ================================================================
  // Helper functions
  // ================================================================
  // Counter that a general register belongs to
  function automatic int gr_cnt(input int g);
    if (g < tgcc_pkg::GR_CH3_FIRST) begin
      return 0;
    end else if (g < tgcc_pkg::GR_CH4_FIRST) begin
      return 1;
    end else if (g < tgcc_pkg::GR_CH5_FIRST) begin
      return 2;
    end else if (g < tgcc_pkg::GR_CH11_FIRST) begin
      return 3;
    end
    return 4;
  endfunction

  // First general register of a counter
  function automatic int cnt_first(input int c);
    case (c)
      0: return 0;
      1: return tgcc_pkg::GR_CH3_FIRST;
      2: return tgcc_pkg::GR_CH4_FIRST;
      3: return tgcc_pkg::GR_CH5_FIRST;
      default: return tgcc_pkg::GR_CH11_FIRST;
    endcase
  endfunction

  // Registers of channels 3 to 5 carry clear enables
  function automatic logic is_ch345(input int g);
    return (g >= tgcc_pkg::GR_CH3_FIRST) && (g < tgcc_pkg::GR_CH11_FIRST);
  endfunction

  // Word address hit
  function automatic logic hit(input logic [11:0] a, input logic [11:0] base, input int i);
    return a == (base + 12'(4 * i));
  endfunction

  // Flag index to its register and bit
  function automatic int flag_reg(input int f);
    return (f < tgcc_pkg::NUM_GR) ? gr_cnt(f) : f - tgcc_pkg::NUM_GR;
  endfunction

  function automatic int flag_bit(input int f);
    return (f < tgcc_pkg::NUM_GR) ? f - cnt_first(gr_cnt(f)) : tgcc_pkg::OVF_BIT;
  endfunction

  // ================================================================
  // Reset synchroniser
  // ================================================================
  logic rst_s1_q; // First stage, read only by the second
  logic rst_n_q;  // Released reset used everywhere

  // Assert at once, release after two edges
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ================================================================
  // Bus slave: one wait state per transfer
  // ================================================================
  logic acc_q;          // Data phase in progress, holds hready low
  logic wr_q;           // Latched direction
  logic [11:0] addr_q;  // Latched word address
  logic accept;
  logic wr_en;
  logic rd_en;
  logic [31:0] rdata;
  logic [31:0] hrdata_q;

  assign accept = hsel_i && hready_i && htrans_i[1];
  assign wr_en = acc_q && wr_q;
  assign rd_en = acc_q && !wr_q;
  assign hreadyout_o = !acc_q;
  assign hresp_o = 1'b0;              // Always OKAY
  assign hrdata_o = hrdata_q;

  // Address phase capture; the wait state lets writes land before reads
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      acc_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 12'h000;
    end else begin
      acc_q <= accept;
      if (accept) begin
        wr_q <= hwrite_i;
        addr_q <= {haddr_i[11:2], 2'b00};
      end
    end
  end

  // Read data registered in the wait cycle
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      hrdata_q <= rdata;
    end
  end

  // ================================================================
  // Storage
  // ================================================================
  logic [7:0] mode_q [tgcc_pkg::NUM_MODE];     // Pin function control
  logic [15:0] gr_q [tgcc_pkg::NUM_GR];        // General registers
  logic [15:0] cnt_q [tgcc_pkg::NUM_CNT];      // Free-running counters
  logic [4:0] run_q;                           // Counter run enables
  logic [tgcc_pkg::NUM_FLAG-1:0] flag_q;       // Capture/match then overflow flags
  logic [tgcc_pkg::NUM_FLAG-1:0] arm_q;        // Flag seen at one by a read
  logic [tgcc_pkg::NUM_FLAG-1:0] ien_q;        // Interrupt enables, same layout
  logic [21:0] pin_s1_q;                       // Pin sync first stage
  logic [21:0] pin_s2_q;                       // Pin sync second stage
  logic [21:0] pin_s3_q;                       // Previous value for edges
  logic [21:0] pin_q;
  logic [21:0] pin_oe_q;
  logic irq_q;

  // Decoded per register
  logic [2:0] md [tgcc_pkg::NUM_GR];           // Mode field
  logic [tgcc_pkg::NUM_GR-1:0] cci;            // Counter clear enable
  logic [tgcc_pkg::NUM_GR-1:0] wlock;          // Software write refused
  logic [tgcc_pkg::NUM_GR-1:0] match_ev;
  logic [tgcc_pkg::NUM_GR-1:0] cap_ev;
  logic [tgcc_pkg::NUM_CNT-1:0] cnt_clr;
  logic [tgcc_pkg::NUM_CNT-1:0] cnt_wr;
  logic [tgcc_pkg::NUM_CNT-1:0] ovf_ev;
  logic [tgcc_pkg::NUM_FLAG-1:0] flag_set;     // Set events in flag order
  logic [21:0] rise;
  logic [21:0] fall;
  logic ch3_match;

  // ================================================================
  // Pin function control registers
  // ================================================================
  // Software writes; ch2 and ch11 hold bits 7 and 3 at zero
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < tgcc_pkg::NUM_MODE; i++) begin
        mode_q[i] <= tgcc_pkg::MODE_RST;
      end
    end else if (standby_i) begin
      for (int i = 0; i < tgcc_pkg::NUM_MODE; i++) begin
        mode_q[i] <= tgcc_pkg::MODE_RST;
      end
    end else if (wr_en) begin
      for (int i = 0; i < tgcc_pkg::NUM_MODE; i++) begin
        if (hit(addr_q, tgcc_pkg::MODE_BASE, i)) begin
          // Registers 4..9 are ch3..5, the rest keep reserved bits clear
          mode_q[i] <= hwdata_i[7:0] & ((i >= 4 && i <= 9) ?
            tgcc_pkg::MASK_FULL : tgcc_pkg::MASK_RSVD);
        end
      end
    end
  end

  // Low nibble is the first register of a pair, high nibble the second
  always_comb begin
    for (int g = 0; g < tgcc_pkg::NUM_GR; g++) begin
      md[g] = g[0] ? mode_q[g/2][6:4] : mode_q[g/2][2:0];
      cci[g] = is_ch345(g) && (g[0] ? mode_q[g/2][7] : mode_q[g/2][3]);
      // Pin-edge capture locks; ch3 locks in capture-off too
      wlock[g] = (md[g][2] && (md[g][1:0] != 2'b00)) ||
        (md[g] == tgcc_pkg::MD_CAP_OFF && g >= tgcc_pkg::GR_CH3_FIRST &&
         g < tgcc_pkg::GR_CH4_FIRST);
    end
  end

  // ================================================================
  // Pin synchroniser and edge detect
  // ================================================================
  // Two flops before the edge stage so each edge gives one event
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_s1_q <= 22'h0;
      pin_s2_q <= 22'h0;
      pin_s3_q <= 22'h0;
    end else begin
      pin_s1_q <= timer_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign rise = pin_s2_q & ~pin_s3_q;
  assign fall = ~pin_s2_q & pin_s3_q;

  // ================================================================
  // Compare and capture events
  // ================================================================
  assign ch3_match = |match_ev[tgcc_pkg::GR_CH4_FIRST-1:tgcc_pkg::GR_CH3_FIRST];

  // Compare needs a running counter so a halted counter on the match value fires no event
  always_comb begin
    for (int g = 0; g < tgcc_pkg::NUM_GR; g++) begin
      match_ev[g] = !md[g][2] && (md[g] != tgcc_pkg::MD_CMP_OFF) &&
        run_q[gr_cnt(g)] && (cnt_q[gr_cnt(g)] == gr_q[g]);
      unique case (md[g])
        tgcc_pkg::MD_CAP_RISE: cap_ev[g] = rise[g];
        tgcc_pkg::MD_CAP_FALL: cap_ev[g] = fall[g];
        tgcc_pkg::MD_CAP_BOTH: cap_ev[g] = rise[g] | fall[g];
        default: cap_ev[g] = 1'b0;
      endcase
      // Ch3..5 in any capture mode also take the ch3/ch9 match trigger
      if (md[g][2] && is_ch345(g) && (ch3_match || ch9_match_i)) begin
        cap_ev[g] = 1'b1;
      end
    end
  end

  // ================================================================
  // General registers
  // ================================================================
  // Capture takes priority; refused writes leave the value untouched
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int g = 0; g < tgcc_pkg::NUM_GR; g++) begin
        gr_q[g] <= 16'hffff;
      end
    end else if (standby_i) begin
      for (int g = 0; g < tgcc_pkg::NUM_GR; g++) begin
        gr_q[g] <= 16'hffff;
      end
    end else begin
      for (int g = 0; g < tgcc_pkg::NUM_GR; g++) begin
        if (cap_ev[g]) begin
          gr_q[g] <= cnt_q[gr_cnt(g)];
        end else if (wr_en && hit(addr_q, tgcc_pkg::GR_BASE, g) && !wlock[g]) begin
          gr_q[g] <= hwdata_i[15:0];
        end
      end
    end
  end

  // ================================================================
  // Free-running counters
  // ================================================================
  // Clear requests only from compare-mode registers with clear enabled
  always_comb begin
    for (int c = 0; c < tgcc_pkg::NUM_CNT; c++) begin
      cnt_clr[c] = 1'b0;
      cnt_wr[c] = wr_en && hit(addr_q, tgcc_pkg::CNT_BASE, c);
    end
    for (int g = 0; g < tgcc_pkg::NUM_GR; g++) begin
      if (cci[g] && match_ev[g]) begin
        cnt_clr[gr_cnt(g)] = 1'b1;
      end
    end
    for (int c = 0; c < tgcc_pkg::NUM_CNT; c++) begin
      ovf_ev[c] = run_q[c] && !cnt_clr[c] && !cnt_wr[c] &&
        (cnt_q[c] == tgcc_pkg::CNT_MAX);
    end
  end

  // Clear beats a software write, which beats counting
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int c = 0; c < tgcc_pkg::NUM_CNT; c++) begin
        cnt_q[c] <= 16'h0000;
      end
    end else if (standby_i) begin
      for (int c = 0; c < tgcc_pkg::NUM_CNT; c++) begin
        cnt_q[c] <= 16'h0000;
      end
    end else begin
      for (int c = 0; c < tgcc_pkg::NUM_CNT; c++) begin
        if (cnt_clr[c]) begin
          cnt_q[c] <= 16'h0000;
        end else if (cnt_wr[c]) begin
          cnt_q[c] <= hwdata_i[15:0];
        end else if (run_q[c]) begin
          cnt_q[c] <= cnt_q[c] + 16'h0001;
        end
      end
    end
  end

  // Run bits
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      run_q <= 5'h00;
    end else if (standby_i) begin
      run_q <= 5'h00;
    end else if (wr_en && addr_q == tgcc_pkg::RUN_ADDR) begin
      run_q <= hwdata_i[4:0];
    end
  end

  // ================================================================
  // Pin outputs
  // ================================================================
  // Enable only for an active compare code; code 000 leaves the pin free
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_q <= 22'h0;
      pin_oe_q <= 22'h0;
    end else if (standby_i) begin
      pin_q <= 22'h0;
      pin_oe_q <= 22'h0;
    end else begin
      for (int g = 0; g < tgcc_pkg::NUM_GR; g++) begin
        pin_oe_q[g] <= !md[g][2] && (md[g] != tgcc_pkg::MD_CMP_OFF);
        if (match_ev[g]) begin
          unique case (md[g])
            tgcc_pkg::MD_CMP_LOW: pin_q[g] <= 1'b0;
            tgcc_pkg::MD_CMP_HIGH: pin_q[g] <= 1'b1;
            default: pin_q[g] <= !pin_q[g];
          endcase
        end
      end
    end
  end

  assign timer_pin_o = pin_q;
  assign timer_pin_oe_o = pin_oe_q;

  // ================================================================
  // Flags and interrupt enables
  // ================================================================
  // One vector so no index ever runs past either source
  assign flag_set = {ovf_ev, cap_ev | match_ev};

  // A set in the same cycle as a clear wins
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flag_q <= '0;
      arm_q <= '0;
    end else if (standby_i) begin
      flag_q <= '0;
      arm_q <= '0;
    end else begin
      for (int f = 0; f < tgcc_pkg::NUM_FLAG; f++) begin
        if (flag_set[f]) begin
          flag_q[f] <= 1'b1;
        end else if (wr_en && arm_q[f] && !hwdata_i[flag_bit(f)] &&
                     hit(addr_q, tgcc_pkg::FLAG_BASE, flag_reg(f))) begin
          flag_q[f] <= 1'b0;
        end
        // Arm on a read that sees the flag at one
        if (rd_en && flag_q[f] && hit(addr_q, tgcc_pkg::FLAG_BASE, flag_reg(f))) begin
          arm_q[f] <= 1'b1;
        end else if (!flag_q[f]) begin
          arm_q[f] <= 1'b0;
        end
      end
    end
  end

  // Enable bits sit at the same positions as their flags
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ien_q <= '0;
    end else if (standby_i) begin
      ien_q <= '0;
    end else if (wr_en) begin
      for (int f = 0; f < tgcc_pkg::NUM_FLAG; f++) begin
        if (hit(addr_q, tgcc_pkg::IEN_BASE, flag_reg(f))) begin
          ien_q[f] <= hwdata_i[flag_bit(f)];
        end
      end
    end
  end

  // Level request, one cycle behind the flags
  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flag_q & ien_q);
    end
  end

  assign irq_o = irq_q;

  // ================================================================
  // Read mux
  // ================================================================
  // Unmapped words and unused bits read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    for (int i = 0; i < tgcc_pkg::NUM_MODE; i++) begin
      if (hit(addr_q, tgcc_pkg::MODE_BASE, i)) begin
        rdata[7:0] = mode_q[i];
      end
    end
    for (int g = 0; g < tgcc_pkg::NUM_GR; g++) begin
      if (hit(addr_q, tgcc_pkg::GR_BASE, g)) begin
        rdata[15:0] = gr_q[g];
      end
    end
    for (int c = 0; c < tgcc_pkg::NUM_CNT; c++) begin
      if (hit(addr_q, tgcc_pkg::CNT_BASE, c)) begin
        rdata[15:0] = cnt_q[c];
      end
    end
    for (int f = 0; f < tgcc_pkg::NUM_FLAG; f++) begin
      if (hit(addr_q, tgcc_pkg::FLAG_BASE, flag_reg(f))) begin
        rdata[flag_bit(f)] = flag_q[f];
      end
      if (hit(addr_q, tgcc_pkg::IEN_BASE, flag_reg(f))) begin
        rdata[flag_bit(f)] = ien_q[f];
      end
    end
    if (addr_q == tgcc_pkg::RUN_ADDR) begin
      rdata[4:0] = run_q;
    end
  end

endmodule

// File: tgcc_pin_model.sv
`timescale 1ns/1ps
// ==========================================
// Far-side timer pins and channel 9 trigger
// ==========================================
module tgcc_pin_model #(
  parameter int LAG = 2  // Pin lag in clock periods on top of 7 ns, 0 leaves 7 ns
) (
  input wire logic clk_i,
  input wire logic [21:0] level_i,  // Levels the scenario asks for
  input wire logic ch9_req_i,
  output logic [21:0] pin_o,
  output logic ch9_match_o
);
  logic req_q;  // Previous request, for one pulse per request
  // Pins move off the clock grid, so the sampler sees real asynchrony
  initial pin_o = 22'h0;
  always @(level_i) pin_o <= #(7 + LAG * 25) level_i;
  // One-cycle match pulse on each request
  always_ff @(posedge clk_i) begin
    req_q <= ch9_req_i;
    ch9_match_o <= ch9_req_i & ~req_q;
  end
endmodule

// File: tgcc_core_assertions.sv
`timescale 1ns/1ps
// ==========================================
// Bus, pin and interrupt invariants
// ==========================================
module tgcc_checker (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic standby_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  input wire logic [21:0] timer_pin_o,
  input wire logic [21:0] timer_pin_oe_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic acc = hsel_i && hready_i && htrans_i[1];  // Transfer taken
  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("Bus response not OKAY");
  a_wait_one: assert property (acc |=> !hreadyout_o ##1 hreadyout_o)
    else $error("Wait state not exactly one cycle");
  a_ready_cause: assert property ($fell(hreadyout_o) |-> $past(acc))
    else $error("Wait state without a transfer");
  a_rdata_hold: assert property ($changed(hrdata_o) |-> $past(acc) || $past(acc, 2)
    || $past(standby_i))
    else $error("Read data moved without a read");
  a_oe_cause: assert property ($changed(timer_pin_oe_o) |-> !$past(hreadyout_o)
    || !$past(hreadyout_o, 2) || $past(standby_i) || $past(standby_i, 2))
    else $error("Pin enable moved without a mode write");
  a_stby_clear: assert property (standby_i [*3] |-> !irq_o && timer_pin_oe_o == 22'h0)
    else $error("Standby left outputs active");
  a_irq_fall: assert property ($fell(irq_o) |-> !$past(hreadyout_o) || !$past(hreadyout_o, 2)
    || $past(standby_i) || $past(standby_i, 2))
    else $error("Interrupt dropped without a write");
  a_pin_oe: assert property (((timer_pin_o ^ $past(timer_pin_o)) & ~(timer_pin_oe_o
    | $past(timer_pin_oe_o))) == 22'h0 || $past(standby_i))
    else $error("Undriven compare pin changed");
endmodule

bind tgcc_core tgcc_checker i_chk (.core_clk_i, .resetn_i, .standby_i, .hsel_i, .htrans_i,
  .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .timer_pin_o, .timer_pin_oe_o, .irq_o);

// File: timer_gr_capture_compare_control_tb_top.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench
// ==========================================
module timer_gr_capture_compare_control_tb_top;
  logic clk, rst_n, stby, hsel, hwrite, hrdy, hresp, irq, ch9_req, ch9;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, hw;
  logic [21:0] lvl, pin_i, pin_o, pin_oe;
  int error_cnt, total_checks, seed, c, pin_m;
  int mode_m [11];  // Expected mode register contents
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  tgcc_core i_dut (.core_clk_i(clk), .resetn_i(rst_n), .standby_i(stby), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
    .timer_pin_i(pin_i), .timer_pin_o(pin_o), .timer_pin_oe_o(pin_oe),
    .ch9_match_i(ch9), .irq_o(irq));
  tgcc_pin_model #(.LAG(2)) i_pins (.clk_i(clk), .level_i(lvl), .ch9_req_i(ch9_req),
    .pin_o(pin_i), .ch9_match_o(ch9));
  function automatic logic [11:0] ad(input logic [11:0] b, input int i);
    return b + 12'(4 * i);
  endfunction
  // One single word transfer; held until ready is sampled high
  task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {20'h0, a}; hwrite <= w;
    @(posedge clk); while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    @(posedge clk); while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0); chk(rd, exp);
  endtask
  // Read arms the clear, then zero in one bit clears it and ones keep the rest
  task flag(input int ch, input int b, input logic exp);
    bus(1'b0, ad(tgcc_pkg::FLAG_BASE, ch), 32'h0); chk({31'h0, rd[b]}, {31'h0, exp});
    bus(1'b1, ad(tgcc_pkg::FLAG_BASE, ch), ~(32'h1 << b));
  endtask
  task run(input logic [11:0] a, input logic [31:0] v, input logic [31:0] r, input int n);
    bus(1'b1, a, v); bus(1'b1, tgcc_pkg::RUN_ADDR, r);
    repeat (n) @(posedge clk); bus(1'b1, tgcc_pkg::RUN_ADDR, 32'h0);
  endtask
  task summarize;
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard, well past the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize;
  end
  initial begin
    seed = 32'h93265a48; rst_n = 1'b0; stby = 1'b0; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0; lvl = 22'h0; ch9_req = 1'b0; pin_m = 0;
    repeat (10) @(posedge clk); rst_n <= 1'b1; repeat (3) @(posedge clk);
    for (c = 0; c < 11; c++) rdchk(ad(tgcc_pkg::MODE_BASE, c), 32'h0);
    for (c = 0; c < 5; c++) rdchk(ad(tgcc_pkg::FLAG_BASE, c), 32'h0);
    rdchk(12'h200, 32'h0);
    for (c = 0; c < 11; c++) begin
      hw = $random(seed) & ((c < 4 || c == 10) ? 32'h77 : 32'hff);
      bus(1'b1, ad(tgcc_pkg::MODE_BASE, c), hw);
      mode_m[c] = hw[7:0] & ((c < 4 || c == 10) ? 8'h77 : 8'hff);
      rdchk(ad(tgcc_pkg::MODE_BASE, c), mode_m[c]);
    end
    $display("Test reset and mode registers done");
    stby <= 1'b1; repeat (3) @(posedge clk); stby <= 1'b0; @(posedge clk);
    for (c = 0; c < 11; c++) rdchk(ad(tgcc_pkg::MODE_BASE, c), 32'h0);
    // Compare codes 001..011 on the first channel 2 register
    bus(1'b1, tgcc_pkg::IEN_BASE, 32'h1); bus(1'b1, tgcc_pkg::GR_BASE, 32'd20);
    for (c = 1; c < 4; c++) begin
      bus(1'b1, tgcc_pkg::MODE_BASE, c); run(tgcc_pkg::CNT_BASE, 32'h0, 32'h1, 30);
      pin_m = (c == 1) ? 0 : ((c == 2) ? 1 : pin_m ^ 1);
      chk({31'h0, pin_o[0]}, pin_m);
      chk({30'h0, pin_oe[1:0]}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rdchk(tgcc_pkg::FLAG_BASE, 32'h1);
      bus(1'b1, tgcc_pkg::FLAG_BASE, 32'h1ff);
      flag(0, 0, 1'b1);
      rdchk(tgcc_pkg::FLAG_BASE, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    run(tgcc_pkg::CNT_BASE, 32'hfff0, 32'h1, 30); flag(0, tgcc_pkg::OVF_BIT, 1'b1);
    $display("Test compare done");
    // Counter clear on channel 3, then blocked in capture mode
    bus(1'b1, ad(tgcc_pkg::GR_BASE, 8), 32'd10); bus(1'b1, ad(tgcc_pkg::MODE_BASE, 4), 32'h9);
    run(ad(tgcc_pkg::CNT_BASE, 1), 32'h0, 32'h2, 40);
    bus(1'b0, ad(tgcc_pkg::CNT_BASE, 1), 32'h0); chk(32'(rd > 32'd10), 32'h0);
    bus(1'b1, ad(tgcc_pkg::MODE_BASE, 4), 32'hc); run(ad(tgcc_pkg::CNT_BASE, 1), 32'h0, 32'h2, 40);
    bus(1'b0, ad(tgcc_pkg::CNT_BASE, 1), 32'h0); chk(32'(rd > 32'd10), 32'h1);
    bus(1'b1, ad(tgcc_pkg::GR_BASE, 8), 32'h3333); rdchk(ad(tgcc_pkg::GR_BASE, 8), 32'd10);
    // Channel 4 capture-off stays writable; channel 9 match captures
    bus(1'b1, ad(tgcc_pkg::MODE_BASE, 6), 32'h4); bus(1'b1, ad(tgcc_pkg::GR_BASE, 12), 32'h1234);
    rdchk(ad(tgcc_pkg::GR_BASE, 12), 32'h1234);
    ch9_req <= 1'b1; repeat (3) @(posedge clk); ch9_req <= 1'b0; repeat (3) @(posedge clk);
    flag(2, 0, 1'b1);
    rdchk(ad(tgcc_pkg::GR_BASE, 12), 32'h0);
    $display("Test clear and trigger done");
    // Pin edges under capture codes 101..111 on the second channel 2 register
    bus(1'b1, tgcc_pkg::MODE_BASE, 32'h50); bus(1'b1, ad(tgcc_pkg::GR_BASE, 1), 32'h55);
    rdchk(ad(tgcc_pkg::GR_BASE, 1), 32'hffff);
    for (c = 5; c < 8; c++) begin
      bus(1'b1, tgcc_pkg::MODE_BASE, c << 4);
      lvl[1] <= 1'b1; repeat (8) @(posedge clk); flag(0, 1, c != 6);
      lvl[1] <= 1'b0; repeat (8) @(posedge clk); flag(0, 1, c != 5);
    end
    $display("Test capture done");
    summarize;
  end
endmodule
